// ==== core/rsc_pkg.sv ====
package rsc_pkg;
    // ==========================================================
    // bus geometry and register word indices
    // ==========================================================
    localparam int RSC_ADR_W = 12;
    localparam int RSC_IDX_W = 10;
    localparam logic [9:0] RSC_IDX_SMC = 10'h0FF;
    localparam logic [9:0] RSC_IDX_CAUSE = 10'h0FE;

    // ==========================================================
    // field positions
    // ==========================================================
    localparam int RSC_SMC_EN_BIT = 7;
    localparam int RSC_SMC_STAT_BIT = 6;
    localparam int RSC_RC_PIN = 0;
    localparam int RSC_RC_POR = 1;
    localparam int RSC_RC_CLK = 2;
    localparam int RSC_RC_WDT = 3;
    localparam int RSC_RC_SW = 4;
    localparam int RSC_RC_CMP = 5;
    localparam int RSC_RC_MEM = 6;

    // ==========================================================
    // reset values
    // ==========================================================
    localparam logic RSC_SMC_EN_RST = 1'b1;
    localparam logic RSC_SUPPLY_SEL_POR = 1'b1;
    localparam logic [7:0] RSC_CAUSE_POR = 8'h02;
    localparam logic [7:0] RSC_FLAGS_RST = 8'h00;

    // ==========================================================
    // timing
    // ==========================================================
    localparam int RSC_CLK_MHZ = 125;
    localparam int RSC_CLK_LOSS_US = 100;
    localparam int RSC_CLK_LOSS_CYC = RSC_CLK_LOSS_US * RSC_CLK_MHZ;
    localparam logic [3:0] RSC_WDT_DIV = 4'hC;
    localparam logic [3:0] RSC_HOLD_CYC = 4'h8;

    typedef enum logic [1:0] {
        RSC_ST_RUN = 2'b01,
        RSC_ST_HOLD = 2'b10
    } rsc_state_t;
endpackage

// ==== core/rsc_reset_source.sv ====
// Register access over Wishbone was decided locally.
`timescale 1ns/1ns
// Function
// - supply monitor enable bit 7; monitor resets only when also selected
// - bit 6 shows live supply monitor output, 1 above threshold
// - six low bits of monitor control read zero, writes ignored
// - low level on external reset pin holds device in reset
// - leaving a pin reset sets pin flag bit 0
// - enabled clock-loss detector resets after 100 us of stopped clock
// - clock-loss flag bit 2 reads 1 only after clock-loss reset
// - writing bit 2 enables or disables the clock-loss detector
// - internal resets other than supply leave reset pin undriven
// - writing 1 to bit 5 selects comparator as reset source
// - selected comparator holds reset while its output is low
// - comparator flag reads 1 only after comparator reset
// - after any reset watchdog enabled, ticking at clock over 12
// - watchdog expiry resets and sets flag bit 3
// - illegal code-space access of any kind causes reset
// - code-space error reset sets flag bit 6
// - writing 1 to bit 4 forces reset; bit reads 1 afterwards
// - power-on or supply reset sets flag bit 1
// - power-on flag clears others; other resets clear power-on flag
// - power-on and supply resets drive reset pin low
// - monitor enable forced on by power-on only, kept otherwise
module rsc_reset_source #(
    parameter int CLK_LOSS_CYCLES = rsc_pkg::RSC_CLK_LOSS_CYC
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic [rsc_pkg::RSC_ADR_W-1:0] wb_adr_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic wb_we_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic supply_above_i,
    input wire logic rst_pin_n_i,
    output logic rst_pin_o,
    output logic rst_pin_oe_o,
    input wire logic mon_clk_i,
    input wire logic comparator_out_i,
    input wire logic wdt_expire_i,
    input wire logic wdt_disable_i,
    input wire logic code_access_illegal_i,
    output logic sys_rst_o,
    output logic supply_monitor_on_o,
    output logic wdt_enable_o,
    output logic wdt_tick_o
);
    import rsc_pkg::*;

    if (CLK_LOSS_CYCLES < 2 || CLK_LOSS_CYCLES > 65535) begin : g_chk
        $error("CLK_LOSS_CYCLES must lie in 2..65535");
    end

    // ==========================================================
    // state
    // ==========================================================
    rsc_state_t state_ff;
    logic [7:0] cause_ff;
    logic [7:0] flags_ff;
    logic [3:0] hold_ff;
    logic por_ff;
    logic supply_en_ff;
    logic supply_sel_ff;
    logic clk_en_ff;
    logic cmp_sel_ff;
    logic mon_prev_ff;
    logic [15:0] cl_cnt_ff;
    logic [3:0] div_ff;
    logic ack_ff;
    logic [31:0] dat_ff;
    logic sys_rst_ff;
    logic oe_ff;
    logic wdt_en_ff;
    logic tick_ff;

    // fixed priority: supply/power first, then pin, then internal events
    function automatic logic [7:0] rsc_pick(input logic [7:0] s);
        logic [7:0] r;
        r = 8'h00;
        if (s[RSC_RC_POR]) r[RSC_RC_POR] = 1'b1;
        else if (s[RSC_RC_PIN]) r[RSC_RC_PIN] = 1'b1;
        else if (s[RSC_RC_CLK]) r[RSC_RC_CLK] = 1'b1;
        else if (s[RSC_RC_MEM]) r[RSC_RC_MEM] = 1'b1;
        else if (s[RSC_RC_WDT]) r[RSC_RC_WDT] = 1'b1;
        else if (s[RSC_RC_CMP]) r[RSC_RC_CMP] = 1'b1;
        else if (s[RSC_RC_SW]) r[RSC_RC_SW] = 1'b1;
        return r;
    endfunction

    // ==========================================================
    // bus decode
    // ==========================================================
    wire [RSC_IDX_W-1:0] word_idx = wb_adr_i[RSC_ADR_W-1:2];
    wire hit_smc = (word_idx == RSC_IDX_SMC);
    wire hit_cause = (word_idx == RSC_IDX_CAUSE);
    wire req = wb_cyc_i & wb_stb_i;
    // write lands on the edge the master sees ack
    wire wr_fire = req & wb_we_i & ack_ff & wb_sel_i[0];
    // writes during reset are acked but dropped
    wire in_run = (state_ff == RSC_ST_RUN);
    wire wr_smc = wr_fire & hit_smc & in_run;
    wire wr_cause = wr_fire & hit_cause & in_run;
    wire [7:0] smc_rd = {supply_en_ff, supply_above_i, 6'h00};
    wire [7:0] cause_rd = {1'b0, flags_ff[6:0]};
    wire [7:0] rd_byte = hit_smc ? smc_rd : (hit_cause ? cause_rd : 8'h00);

    // ==========================================================
    // reset sources
    // ==========================================================
    wire supply_trip = supply_en_ff & supply_sel_ff & ~supply_above_i;
    wire cmp_trip = cmp_sel_ff & ~comparator_out_i;
    wire cl_evt = clk_en_ff & (cl_cnt_ff == 16'(CLK_LOSS_CYCLES));
    wire sw_force = wr_cause & wb_dat_i[RSC_RC_SW];
    wire [7:0] lvl_src = {2'b00, cmp_trip, 3'b000, supply_trip, ~rst_pin_n_i};
    wire [7:0] src = lvl_src
        | {1'b0, code_access_illegal_i, 1'b0, sw_force, wdt_expire_i, cl_evt, 2'b00};
    wire [7:0] pick = rsc_pick(src);
    wire any_src = |src;
    wire lvl_held = |(cause_ff & lvl_src);
    wire hold_done = (hold_ff == 4'h0);
    wire leave = (state_ff == RSC_ST_HOLD) & hold_done & ~lvl_held;
    wire enter = in_run & any_src;
    wire drive_pin = pick[RSC_RC_POR];

    // ==========================================================
    // sequencer
    // ==========================================================
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state_ff <= RSC_ST_HOLD;
            cause_ff <= RSC_CAUSE_POR;
            hold_ff <= RSC_HOLD_CYC;
            por_ff <= 1'b1;
            sys_rst_ff <= 1'b1;
            oe_ff <= 1'b1;
        end else if (enter) begin
            state_ff <= RSC_ST_HOLD;
            cause_ff <= pick;
            hold_ff <= RSC_HOLD_CYC;
            sys_rst_ff <= 1'b1;
            oe_ff <= drive_pin;
        end else if (leave) begin
            state_ff <= RSC_ST_RUN;
            por_ff <= 1'b0;
            sys_rst_ff <= 1'b0;
            oe_ff <= 1'b0;
        end else if (!hold_done) begin
            hold_ff <= hold_ff - 4'h1;
        end
    end

    // flags only move at reset exit; power-on/supply cause carries bit 1 alone
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            flags_ff <= RSC_FLAGS_RST;
        end else if (leave) begin
            flags_ff <= cause_ff;
        end
    end

    // ==========================================================
    // software controls
    // ==========================================================
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            supply_en_ff <= RSC_SMC_EN_RST;
            supply_sel_ff <= RSC_SUPPLY_SEL_POR;
            clk_en_ff <= 1'b0;
            cmp_sel_ff <= 1'b0;
        end else if (leave) begin
            if (por_ff) supply_sel_ff <= RSC_SUPPLY_SEL_POR;
            clk_en_ff <= 1'b0;
            cmp_sel_ff <= 1'b0;
        end else begin
            if (wr_smc) supply_en_ff <= wb_dat_i[RSC_SMC_EN_BIT];
            if (wr_cause) begin
                supply_sel_ff <= wb_dat_i[RSC_RC_POR];
                clk_en_ff <= wb_dat_i[RSC_RC_CLK];
                cmp_sel_ff <= wb_dat_i[RSC_RC_CMP];
            end
        end
    end

    // ==========================================================
    // clock-loss detector: counts cycles the watched clock holds still
    // ==========================================================
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            mon_prev_ff <= 1'b0;
            cl_cnt_ff <= 16'h0000;
        end else begin
            mon_prev_ff <= mon_clk_i;
            if (!clk_en_ff || mon_clk_i != mon_prev_ff || !in_run) begin
                cl_cnt_ff <= 16'h0000;
            end else if (!cl_evt) begin
                cl_cnt_ff <= cl_cnt_ff + 16'h0001;
            end
        end
    end

    // ==========================================================
    // watchdog enable and divide-by-12 tick
    // ==========================================================
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wdt_en_ff <= 1'b1;
            div_ff <= 4'h0;
            tick_ff <= 1'b0;
        end else begin
            if (leave) wdt_en_ff <= 1'b1;
            else if (wdt_disable_i) wdt_en_ff <= 1'b0;
            if (div_ff == RSC_WDT_DIV - 4'h1) begin
                div_ff <= 4'h0;
                tick_ff <= wdt_en_ff;
            end else begin
                div_ff <= div_ff + 4'h1;
                tick_ff <= 1'b0;
            end
        end
    end

    // ==========================================================
    // wishbone answer: ack one cycle after request, unmapped reads zero
    // ==========================================================
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_ff <= 1'b0;
            dat_ff <= 32'h00000000;
        end else begin
            ack_ff <= req & ~ack_ff;
            if (req & ~ack_ff) dat_ff <= {24'h000000, rd_byte};
        end
    end

    assign wb_ack_o = ack_ff;
    assign wb_dat_o = dat_ff;
    assign rst_pin_o = 1'b0;
    assign rst_pin_oe_o = oe_ff;
    assign sys_rst_o = sys_rst_ff;
    assign supply_monitor_on_o = supply_en_ff;
    assign wdt_enable_o = wdt_en_ff;
    assign wdt_tick_o = tick_ff;

    // ==========================================================
    // checks
    // ==========================================================
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    sequence s_read_smc;
        req & ~ack_ff & ~wb_we_i & hit_smc;
    endsequence

    sequence s_exit;
        state_ff == RSC_ST_HOLD ##1 state_ff == RSC_ST_RUN;
    endsequence

    property p_smc_low_zero;
        s_read_smc |=> wb_dat_o[5:0] == 6'h00;
    endproperty
    a_smc_low_zero: assert property (p_smc_low_zero) else $error("low bits not zero");

    property p_smc_stat;
        s_read_smc |=> wb_dat_o[6] == $past(supply_above_i);
    endproperty
    a_smc_stat: assert property (p_smc_stat) else $error("status bit wrong");

    property p_supply_gate;
        in_run && supply_trip |=> sys_rst_o && rst_pin_oe_o;
    endproperty
    a_supply_gate: assert property (p_supply_gate) else $error("supply reset lost");

    property p_pin_enter;
        in_run && !rst_pin_n_i |=> sys_rst_o && cause_ff[RSC_RC_PIN];
    endproperty
    a_pin_enter: assert property (p_pin_enter) else $error("pin reset missed");

    property p_flag_copy;
        s_exit |-> flags_ff == $past(cause_ff) && $onehot(flags_ff);
    endproperty
    a_flag_copy: assert property (p_flag_copy) else $error("flag capture wrong");

    property p_clk_loss;
        in_run && cl_evt |=> sys_rst_o && cause_ff[RSC_RC_CLK] && !rst_pin_oe_o;
    endproperty
    a_clk_loss: assert property (p_clk_loss) else $error("clock loss reset missed");

    property p_sw_force;
        sw_force |=> sys_rst_o ##[1:40] (in_run && flags_ff[RSC_RC_SW]);
    endproperty
    a_sw_force: assert property (p_sw_force) else $error("software reset wrong");

    property p_pin_undriven;
        rst_pin_oe_o |-> cause_ff == RSC_CAUSE_POR && sys_rst_o;
    endproperty
    a_pin_undriven: assert property (p_pin_undriven) else $error("pin driven");

    property p_wdt_on;
        s_exit |-> wdt_enable_o;
    endproperty
    a_wdt_on: assert property (p_wdt_on) else $error("watchdog off after reset");

    property p_hold_min;
        enter |=> sys_rst_o [*8];
    endproperty
    a_hold_min: assert property (p_hold_min) else $error("reset too short");

    // event sources only win when nothing of higher priority is active
    property p_mem_enter;
        in_run && code_access_illegal_i && !cl_evt && !supply_trip && rst_pin_n_i
            |=> sys_rst_o && cause_ff[RSC_RC_MEM] && !rst_pin_oe_o;
    endproperty
    a_mem_enter: assert property (p_mem_enter) else $error("code error reset missed");

    property p_wdt_enter;
        in_run && wdt_expire_i && !code_access_illegal_i && !cl_evt && !supply_trip
            && rst_pin_n_i |=> sys_rst_o && cause_ff[RSC_RC_WDT] && !rst_pin_oe_o;
    endproperty
    a_wdt_enter: assert property (p_wdt_enter) else $error("watchdog reset missed");

    property p_cmp_enter;
        in_run && pick[RSC_RC_CMP] |=> sys_rst_o && cause_ff[RSC_RC_CMP] && !rst_pin_oe_o;
    endproperty
    a_cmp_enter: assert property (p_cmp_enter) else $error("comparator reset missed");

    property p_flags_hold;
        !leave |=> $stable(flags_ff);
    endproperty
    a_flags_hold: assert property (p_flags_hold) else $error("flags moved outside exit");

    property p_monitor_keep;
        !wr_smc |=> $stable(supply_monitor_on_o);
    endproperty
    a_monitor_keep: assert property (p_monitor_keep) else $error("monitor enable moved");

    property p_exit_release;
        leave |=> !sys_rst_o && !rst_pin_oe_o;
    endproperty
    a_exit_release: assert property (p_exit_release) else $error("pin held after exit");

endmodule // rsc_reset_source

// ==== verification/rsc_board.sv ====
`timescale 1ns/1ns
// ==========================================================
// board side: pulled-up reset pin, button, watched clock
// ==========================================================
module rsc_board (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic press_i,
    input wire logic clk_stop_i,
    input wire logic rst_pin_o,
    input wire logic rst_pin_oe_o,
    output logic rst_pin_n_o,
    output logic mon_clk_o
);
    // pull-up wins only when neither the button nor the device sinks the pin
    assign rst_pin_n_o = !press_i && !(rst_pin_oe_o && !rst_pin_o);

    // a stopped clock stands at its last level, which is the loss case
    always @(posedge clk_i) begin
        if (rst_i) begin
            mon_clk_o <= 1'b0;
        end else if (!clk_stop_i) begin
            mon_clk_o <= !mon_clk_o;
        end
    end
endmodule // rsc_board

// ==== verification/tb.sv ====
`timescale 1ns/1ns
module tb;
    import rsc_pkg::*;
    localparam logic [11:0] SMC = {RSC_IDX_SMC, 2'b00};
    localparam logic [11:0] CAUSE = {RSC_IDX_CAUSE, 2'b00};
    logic clk_i, rst_i, wb_we_i, wb_cyc_i, wb_stb_i, supply, comp, wexp, wdis, ill, press, stop;
    logic [11:0] wb_adr_i;
    logic [31:0] wb_dat_i, wb_dat_o, r;
    logic [3:0] wb_sel_i;
    logic wb_ack_o, pin_o, pin_oe, pin_n, mclk, sys_rst_o, mon_on, wdt_enable_o, wdt_tick_o;
    logic [7:0] exp_q[$];
    int fails, n_tests, seed;

    rsc_reset_source #(.CLK_LOSS_CYCLES(20)) dut (.clk_i(clk_i), .rst_i(rst_i),
        .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i), .wb_sel_i(wb_sel_i), .wb_we_i(wb_we_i),
        .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
        .supply_above_i(supply), .rst_pin_n_i(pin_n), .rst_pin_o(pin_o),
        .rst_pin_oe_o(pin_oe), .mon_clk_i(mclk), .comparator_out_i(comp),
        .wdt_expire_i(wexp), .wdt_disable_i(wdis), .code_access_illegal_i(ill),
        .sys_rst_o(sys_rst_o), .supply_monitor_on_o(mon_on), .wdt_enable_o(wdt_enable_o),
        .wdt_tick_o(wdt_tick_o));
    rsc_board board (.clk_i(clk_i), .rst_i(rst_i), .press_i(press), .clk_stop_i(stop),
        .rst_pin_o(pin_o), .rst_pin_oe_o(pin_oe), .rst_pin_n_o(pin_n), .mon_clk_o(mclk));

    initial begin
        clk_i = 1'b0;
        forever #4 clk_i = !clk_i;
    end

    task automatic tally_and_finish();
        if (fails == 0 && n_tests > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    task automatic chk(input logic ok);
        n_tests++;
        if (ok !== 1'b1) begin
            fails++;
            $display("MISMATCH %0t output check", $time);
        end
    endtask

    // classic single cycle: hold everything until ack is sampled
    task automatic wb(input logic [11:0] a, input logic we, input logic [7:0] d);
        int i;
        @(posedge clk_i);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_adr_i <= a;
        wb_we_i <= we;
        wb_dat_i <= {24'h000000, d};
        for (i = 0; i < 20; i++) begin
            @(posedge clk_i);
            if (wb_ack_o === 1'b1) break;
        end
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        wb_we_i <= 1'b0;
        if (i == 20) begin
            fails++;
            $display("MISMATCH %0t bus answer timed out", $time);
            tally_and_finish();
        end
    endtask

    task automatic rd(input logic [11:0] a, input logic [7:0] e);
        exp_q.push_back(e);
        wb(a, 1'b0, 8'h00);
    endtask

    // wait through one whole reset, note pin drive, then read the cause
    task automatic exp_rst(input logic [7:0] f, input logic oe);
        int i;
        logic seen, oes;
        seen = 1'b0;
        oes = 1'b0;
        for (i = 0; i < 200; i++) begin
            @(posedge clk_i);
            if (sys_rst_o === 1'b1) begin
                seen = 1'b1;
                oes = oes | (pin_oe === 1'b1 && pin_o === 1'b0);
            end else if (seen) break;
        end
        if (i == 200) begin
            fails++;
            $display("MISMATCH %0t reset wait timed out", $time);
            tally_and_finish();
        end
        chk(seen && oes === oe);
        rd(CAUSE, f);
    endtask

    task automatic tick_gap();
        int i, n;
        for (i = 0; i < 30; i++) begin
            @(posedge clk_i);
            if (wdt_tick_o === 1'b1) break;
        end
        n = 0;
        for (i = 0; i < 30; i++) begin
            @(posedge clk_i);
            n++;
            if (wdt_tick_o === 1'b1) break;
        end
        chk(n == 12);
    endtask

    // a reset that already ended would hide from a single late look
    task automatic no_reset_for(input int n);
        int i, hits;
        hits = 0;
        for (i = 0; i < n; i++) begin
            @(posedge clk_i);
            if (sys_rst_o !== 1'b0) hits++;
        end
        chk(hits == 0);
    endtask

    // ==========================================================
    // read results are judged here, in order of issue
    // ==========================================================
    always @(posedge clk_i) begin
        if (wb_ack_o === 1'b1 && wb_we_i === 1'b0) begin
            n_tests++;
            if (exp_q.size() == 0 || wb_dat_o !== {24'h000000, exp_q[0]}) begin
                fails++;
                $display("MISMATCH %0t read data %h", $time, wb_dat_o);
            end
            if (exp_q.size() != 0) void'(exp_q.pop_front());
        end
    end

    initial begin
        seed = 32'h16777F8C;
        {rst_i, supply, comp} = 3'b111;
        {wb_we_i, wb_cyc_i, wb_stb_i, wexp, wdis, ill, press, stop} = 8'h00;
        wb_adr_i = 12'h000;
        wb_dat_i = 32'h00000000;
        wb_sel_i = 4'hF;
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        exp_rst(8'h02, 1'b1);
        rd(SMC, 8'hC0);
        chk(mon_on === 1'b1);
        chk(wdt_enable_o === 1'b1);
        tick_gap();
        wb_sel_i <= 4'hE;
        wb(SMC, 1'b1, 8'h00);
        wb_sel_i <= 4'hF;
        rd(SMC, 8'hC0);
        r = $random(seed);
        wb(SMC, 1'b1, {1'b0, r[6:0]});
        rd(SMC, 8'h40);
        supply <= 1'b0;
        rd(SMC, 8'h00);
        chk(sys_rst_o === 1'b0);
        supply <= 1'b1;
        wb(SMC, 1'b1, 8'h80);
        // monitor must settle before it may trip
        repeat (10 + r[11:8]) @(posedge clk_i);
        supply <= 1'b0;
        repeat (4) @(posedge clk_i);
        supply <= 1'b1;
        exp_rst(8'h02, 1'b1);
        wb(SMC, 1'b1, 8'h00);
        wb(CAUSE, 1'b1, 8'h12);
        exp_rst(8'h10, 1'b0);
        rd(SMC, 8'h40);
        chk(mon_on === 1'b0);
        wb(SMC, 1'b1, 8'h80);
        press <= 1'b1;
        repeat (3) @(posedge clk_i);
        press <= 1'b0;
        exp_rst(8'h01, 1'b0);
        wb(CAUSE, 1'b1, 8'h06);
        stop <= 1'b1;
        exp_rst(8'h04, 1'b0);
        stop <= 1'b0;
        repeat (4) @(posedge clk_i);
        stop <= 1'b1;
        no_reset_for(40);
        stop <= 1'b0;
        wb(CAUSE, 1'b1, 8'h04);
        wb(CAUSE, 1'b1, 8'h00);
        stop <= 1'b1;
        no_reset_for(40);
        stop <= 1'b0;
        rd(CAUSE, 8'h04);
        wb(CAUSE, 1'b1, 8'h22);
        // comparator is already settled high before it is selected
        repeat (5) @(posedge clk_i);
        comp <= 1'b0;
        repeat (3) @(posedge clk_i);
        comp <= 1'b1;
        exp_rst(8'h20, 1'b0);
        wdis <= 1'b1;
        @(posedge clk_i);
        wdis <= 1'b0;
        repeat (2) @(posedge clk_i);
        chk(wdt_enable_o === 1'b0);
        ill <= 1'b1;
        @(posedge clk_i);
        ill <= 1'b0;
        // this write lands while held in reset and must be dropped
        wb(SMC, 1'b1, 8'h00);
        exp_rst(8'h40, 1'b0);
        rd(SMC, 8'hC0);
        chk(wdt_enable_o === 1'b1);
        wexp <= 1'b1;
        @(posedge clk_i);
        wexp <= 1'b0;
        exp_rst(8'h08, 1'b0);
        rd(12'h100, 8'h00);
        rd(CAUSE, 8'h08);
        tally_and_finish();
    end
endmodule // tb
